// ==== pulse_counter.sv ====
/*
 * Constants package and the gated up/down pulse counter channel: a 32-bit
 * signed counter with endless, once and periodic modes, optional main
 * direction, abort or interrupt gating and sticky wrap flags, reached over
 * an Avalon-MM slave with waitrequest.
 * Assumes: a single 25 MHz clock, synchronous active-low reset, encoder
 * count and direction lines and the external gate as asynchronous pins,
 * and a bus master that holds its request until waitrequest is low.
 */
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
// Operation
// - Three modes selectable: endless, once, periodic.
// - Once and periodic modes use a range given by load and end values.
// - Without main direction the full signed 32-bit range is used.
// - Forward: count up to end minus one, next pulse returns to load.
// - Backward: count down to end plus one, next pulse returns to load.
// - With external gate enabled, gating acts on it; otherwise on program gate.
// - Abort gating: reopening the gate restarts from the load value.
// - Interrupt gating: reopening the gate resumes from the held value.
// - Endless mode begins counting from the load value.
// - Endless: upward pulse at upper limit wraps to lower limit.
// - Endless: downward pulse at lower limit wraps to upper limit.
// - Overflow and underflow set their flags and, if enabled, an event.
// - Flags stay set until the clear status command.
// - Once without direction: wrap to opposite limit, close gate, set flag.
// - Once without direction, interrupt gating resumes from the last value.
// - Once with abort gating restarts from the load value.
// - Once forward: pulse after end minus one reloads and closes gate.
// - Once with direction restarts from load on a gate rising edge.
// - Internal gate combines external and program gates; external may be off.
package counter_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_LOAD = 8'h04;
  localparam logic [7:0] OFS_END = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;

  // Control field positions
  localparam int CTL_PROGRAM_GATE_CONTROL = 0;
  localparam int CTL_HW_EN = 1;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_DIR_LSB = 4;
  localparam int CTL_GATE_INTR = 6;
  localparam int CTL_EVT_EN = 7;
  localparam int CTL_W = 8;

  // Mode and main direction codes
  localparam logic [1:0] MODE_ENDLESS = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_BWD = 2'h2;

  // Status and command bit positions
  localparam int STS_OVF = 0;
  localparam int STS_UNF = 1;
  localparam int STS_GATE = 2;
  localparam int STS_AUTO = 3;
  localparam int CMD_CLEAR = 0;
  localparam int CMD_LOAD = 1;

  // Count limits and reset values
  localparam logic [31:0] COUNT_MIN = 32'h8000_0000;
  localparam logic [31:0] COUNT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
  localparam logic [31:0] END_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

module pulse_counter
  import counter_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Avalon-MM register slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Encoder and gate pins
  input wire logic encoder_pulse,
  input wire logic encoder_dir,
  input wire logic external_gate_input,
  // Channel state
  output logic overflow_flag,
  output logic underflow_flag,
  output logic gate_open,
  output logic process_event
);

  // Merge write data into a register under byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Refuse constants that the decoder or the bus word cannot carry
  if (DATA_W != 32) begin : g_bad_data
    $error("pulse_counter needs a 32-bit data bus");
  end
  if (CTL_W > 8 || CTL_DIR_LSB + 2 > CTL_W) begin : g_bad_ctl
    $error("pulse_counter control fields overrun the control byte");
  end
  if (ADDR_W < 5) begin : g_bad_addr
    $error("pulse_counter address cannot reach every register");
  end
  if (COUNT_MAX != ~COUNT_MIN) begin : g_bad_limits
    $error("pulse_counter count limits are not the signed extremes");
  end

  // Registers
  logic [CTL_W-1:0] control_q;
  logic [31:0] load_q;
  logic [31:0] end_q;
  logic [31:0] count_q;
  logic overflow_q;
  logic underflow_q;
  logic gate_q;
  logic auto_closed_q;
  logic event_q;
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic pulse_prev_q;
  logic hw_prev_q;
  logic sw_prev_q;

  // Synchronised pins
  logic [2:0] pins_s;
  logic pulse_s;
  logic dir_s;
  logic hw_s;

  // Pin levels shorter than one clock cycle can be lost in the chain
  // Encoder and gate pins are asynchronous to the system clock
  input_sync #(
    .WIDTH(3),
    .STAGES(2)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({external_gate_input, encoder_dir, encoder_pulse}),
    .sync_out(pins_s)
  );

  assign pulse_s = pins_s[0];
  assign dir_s = pins_s[1];
  assign hw_s = pins_s[2];

  // Control fields
  wire program_gate_control = control_q[CTL_PROGRAM_GATE_CONTROL];
  wire hw_en = control_q[CTL_HW_EN];
  wire [1:0] mode = control_q[CTL_MODE_LSB +: 2];
  wire [1:0] dir_field = control_q[CTL_DIR_LSB +: 2];
  wire gate_intr = control_q[CTL_GATE_INTR];
  wire evt_en = control_q[CTL_EVT_EN];

  // Bus handshake: one wait cycle, then a single acknowledged cycle
  wire bus_req = (avs_read || avs_write) && waitrequest_q;
  wire wr_acc = avs_write && !waitrequest_q;
  wire sel_control = avs_address == OFS_CONTROL;
  wire sel_load = avs_address == OFS_LOAD;
  wire sel_end = avs_address == OFS_END;
  wire sel_count = avs_address == OFS_COUNT;
  wire sel_status = avs_address == OFS_STATUS;
  wire sel_command = avs_address == OFS_COMMAND;
  wire wr_control = wr_acc && sel_control;
  wire wr_load = wr_acc && sel_load;
  wire wr_end = wr_acc && sel_end;
  wire wr_command = wr_acc && sel_command && avs_byteenable[0];
  wire clear_status_command = wr_command && avs_writedata[CMD_CLEAR];
  wire load_command = wr_command && avs_writedata[CMD_LOAD];
  wire [31:0] control_wr = merge_be({{(32-CTL_W){1'b0}}, control_q}, avs_writedata,
                                    avs_byteenable);

  // Read selection; unmapped offsets and the command word read as zero
  wire [31:0] status_word = {28'h000_0000, auto_closed_q, gate_q, underflow_q, overflow_q};
  wire [31:0] read_mux = sel_control ? {{(32-CTL_W){1'b0}}, control_q} :
                         sel_load ? load_q :
                         sel_end ? end_q :
                         sel_count ? count_q :
                         sel_status ? status_word :
                         ZERO_WORD;

  // Gate edges and the internal gate level
  wire sw_rise = program_gate_control && !sw_prev_q;
  wire hw_rise = hw_s && !hw_prev_q;
  wire restart_edge = hw_en ? hw_rise : sw_rise;
  wire gate_level = hw_en ? (program_gate_control && hw_s) : program_gate_control;

  // Main direction only shapes the range outside endless mode
  wire [1:0] dir_sel = (mode == MODE_ENDLESS) ? DIR_NONE : dir_field;
  wire [31:0] end_minus1 = end_q - COUNT_ONE;
  wire [31:0] end_plus1 = end_q + COUNT_ONE;

  // Gated pulse steps; closed gate blocks them entirely
  wire pulse_rise = pulse_s && !pulse_prev_q;
  wire up_step = gate_q && pulse_rise && dir_s;
  wire down_step = gate_q && pulse_rise && !dir_s;

  // Range ends
  wire up_at_end = (dir_sel == DIR_FWD) && (count_q == end_minus1);
  wire down_at_end = (dir_sel == DIR_BWD) && (count_q == end_plus1);
  wire up_at_max = count_q == COUNT_MAX;
  wire down_at_min = count_q == COUNT_MIN;

  // Wrap events feed the sticky flags
  wire ovf_evt = up_step && (up_at_end || up_at_max);
  wire unf_evt = down_step && (down_at_end || down_at_min);
  wire wrap_evt = ovf_evt || unf_evt;
  wire auto_close = (mode == MODE_ONCE) && wrap_evt;

  // Next count for a single step; range ends fall back to the load value
  wire [31:0] up_value = up_at_end ? load_q :
                         up_at_max ? COUNT_MIN :
                         count_q + COUNT_ONE;
  wire [31:0] down_value = down_at_end ? load_q :
                           down_at_min ? COUNT_MAX :
                           count_q - COUNT_ONE;

  // Abort gating reloads; a directed single shot always restarts from load
  // An external rise with the program gate off still reloads under abort
  wire restart_load = restart_edge &&
                      (!gate_intr || ((mode == MODE_ONCE) && (dir_sel != DIR_NONE)));

  // Priority: load command, then gate restart, then one pulse step
  wire [31:0] count_d = load_command ? load_q :
                        restart_load ? load_q :
                        up_step ? up_value :
                        down_step ? down_value :
                        count_q;

  // Automatic closure holds until the gate source rises again
  wire auto_closed_d = restart_edge ? 1'b0 :
                       auto_close ? 1'b1 :
                       auto_closed_q;
  // Gate follows its source one edge late and stays shut after an auto close
  wire gate_d = gate_level && !auto_closed_d;

  // Sticky flags: a wrap in the clearing cycle still sets the flag
  wire overflow_d = ovf_evt ? 1'b1 : (clear_status_command ? 1'b0 : overflow_q);
  wire underflow_d = unf_evt ? 1'b1 : (clear_status_command ? 1'b0 : underflow_q);

  // Bus slave handshake and read capture
  // Read data are captured in the stall cycle so they stand in the answer cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      waitrequest_q <= 1'b1;
      readdata_q <= ZERO_WORD;
    end else begin
      waitrequest_q <= !bus_req;
      if (bus_req) begin
        readdata_q <= read_mux;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clock) begin
    if (!rstn) begin
      control_q <= CONTROL_RESET;
      load_q <= LOAD_RESET;
      end_q <= END_RESET;
    end else begin
      if (wr_control) begin
        control_q <= control_wr[CTL_W-1:0];
      end
      if (wr_load) begin
        load_q <= merge_be(load_q, avs_writedata, avs_byteenable);
      end
      if (wr_end) begin
        end_q <= merge_be(end_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // Edge history of the pins and the program gate
  // Reset values match the idle pin levels, so no false edge follows reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pulse_prev_q <= 1'b0;
      hw_prev_q <= 1'b0;
      sw_prev_q <= 1'b0;
    end else begin
      pulse_prev_q <= pulse_s;
      hw_prev_q <= hw_s;
      sw_prev_q <= program_gate_control;
    end
  end

  // Counter, gate and flags
  // The event lasts one cycle; software polls the sticky flags instead
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q <= ZERO_WORD;
      auto_closed_q <= 1'b0;
      gate_q <= 1'b0;
      overflow_q <= 1'b0;
      underflow_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      count_q <= count_d;
      auto_closed_q <= auto_closed_d;
      gate_q <= gate_d;
      overflow_q <= overflow_d;
      underflow_q <= underflow_d;
      event_q <= evt_en && wrap_evt;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitrequest_q;
  assign overflow_flag = overflow_q;
  assign underflow_flag = underflow_q;
  assign gate_open = gate_q;
  assign process_event = event_q;

endmodule

// ==== input_sync.sv ====
/*
 * Multi-stage input synchroniser for pins that arrive from outside the
 * clock domain (encoder lines, external gate).
 * Assumes: one system clock, synchronous active-low reset, and that the
 * caller never reads any stage but the last.
 */
module input_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_q [STAGES];

  // Fewer than two stages would leave metastability exposed
  initial begin
    if (STAGES < 2) begin
      $error("input_sync needs at least two stages");
    end
    if (WIDTH < 1) begin
      $error("input_sync needs a positive width");
    end
  end

  // First stage feeds only the next stage
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage_q[0] <= '0;
    end else begin
      stage_q[0] <= async_in;
    end
  end

  // Remaining stages form a plain shift chain
  for (genvar i = 1; i < STAGES; i++) begin : g_stage
    always_ff @(posedge clock) begin
      if (!rstn) begin
        stage_q[i] <= '0;
      end else begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule

// ==== pulse_counter_monitor.sv ====
/*
 * Checker for the pulse counter: bus handshake, sticky flags and event pulse.
 * Assumes: one clock, synchronous active-low reset, bound to pulse_counter.
 */
module pulse_counter_monitor
  import counter_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Channel state
  input wire logic overflow_flag,
  input wire logic underflow_flag,
  input wire logic gate_open,
  input wire logic process_event
);
  timeunit 1ns;
  timeprecision 1ns;
  // A clear only lands on the accepting edge of a COMMAND write with lane 0
  logic clear_hit;
  assign clear_hit = avs_write && !avs_waitrequest && avs_address == OFS_COMMAND
    && avs_byteenable[0] && avs_writedata[CMD_CLEAR];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Handshake: one stall cycle, then exactly one answer cycle
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  // Flags hold unless a clear is taken
  property p_ovf_hold;
    overflow_flag && !clear_hit |=> overflow_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
  property p_unf_hold;
    underflow_flag && !clear_hit |=> underflow_flag;
  endproperty
  a_unf_hold: assert property (p_unf_hold) else $error("underflow lost");
  // The event comes with a flag, lasts one cycle and needs an open gate
  property p_event_flag;
    process_event |-> overflow_flag || underflow_flag;
  endproperty
  a_event_flag: assert property (p_event_flag) else $error("event without flag");
  property p_event_once;
    process_event |=> !process_event;
  endproperty
  a_event_once: assert property (p_event_once) else $error("event too long");
  property p_event_gate;
    process_event |-> $past(gate_open);
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("event gate shut");
  property p_reset_clean;
    $rose(rstn) |-> !overflow_flag && !underflow_flag && !gate_open && avs_waitrequest;
  endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("reset state wrong");
endmodule

bind pulse_counter pulse_counter_monitor i_pulse_counter_monitor (.clock, .rstn,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .overflow_flag, .underflow_flag, .gate_open, .process_event);

// ==== encoder_model.sv ====
/*
 * Encoder model: count pulses with direction set up one hold ahead.
 * Assumes: callers give a hold of at least 2 cycles per level.
 */
module encoder_model (
  // Clock
  input wire logic clock,
  // Encoder pins
  output logic encoder_pulse,
  output logic encoder_dir
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle low
  initial begin
    encoder_pulse = 1'b0;
    encoder_dir = 1'b0;
  end
  // Slow holds stress the sync chain less but prove no edge is lost
  task automatic pulses(input int n, input logic up, input int hold);
    repeat (n) begin
      @(posedge clock);
      encoder_dir <= up;
      repeat (hold) @(posedge clock);
      encoder_pulse <= 1'b1;
      repeat (hold) @(posedge clock);
      encoder_pulse <= 1'b0;
    end
  endtask
endmodule

// ==== tb.sv ====
/*
 * Bench for the pulse counter: a table of counting cases, then hand tests.
 * Assumes: counter_pkg, pulse_counter, encoder_model and the bound monitor.
 */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import counter_pkg::*;
  typedef struct {
    logic [7:0] ctl;
    logic [31:0] load, fin;
    int n;
    logic up;
    logic [31:0] count, status, events;
  } row_s;
  row_s rows [8];
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic external_gate_input = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic [31:0] event_count = 32'h0;
  logic [31:0] event_base = 32'h0;
  logic avs_waitrequest, encoder_pulse, encoder_dir;
  logic overflow_flag, underflow_flag, gate_open, process_event;
  int compares = 0;
  int miscompares = 0;
  // Clock and event tally
  always #20 clock = ~clock;
  always @(posedge clock) if (process_event === 1'b1) event_count <= event_count + 1;
  pulse_counter i_pulse_counter (.clock, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .encoder_pulse,
    .encoder_dir, .external_gate_input, .overflow_flag, .underflow_flag, .gate_open,
    .process_event);
  encoder_model i_encoder_model (.clock, .encoder_pulse, .encoder_dir);
  task automatic report_and_stop;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; a stuck slave ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask
  // Configure with the gate shut, clear flags, copy load, then open the gate
  task automatic arm(input logic [7:0] ctl, input logic [31:0] load, input logic [31:0] fin);
    bus(1'b1, OFS_CONTROL, {24'h0, ctl}, 4'hF);
    bus(1'b1, OFS_LOAD, load, 4'hF);
    bus(1'b1, OFS_END, fin, 4'hF);
    bus(1'b1, OFS_COMMAND, 32'h3, 4'hF);
    bus(1'b1, OFS_CONTROL, {24'h0, ctl | 8'h01}, 4'hF);
    event_base = event_count;
  endtask
  task automatic step(input int n, input logic up, input int hold);
    i_encoder_model.pulses(n, up, hold);
    repeat (6) @(posedge clock);
  endtask
  // Main sequence
  initial begin
    logic [7:0] c;
    rows = '{'{8'h80, 32'h5, 32'h0, 3, 1'b1, 32'h8, 32'h4, 32'h0},
      '{8'h80, 32'h7FFF_FFFE, 32'h0, 2, 1'b1, 32'h8000_0000, 32'h5, 32'h1},
      '{8'h80, 32'h8000_0001, 32'h0, 2, 1'b0, 32'h7FFF_FFFF, 32'h6, 32'h1},
      '{8'h98, 32'h2, 32'h5, 4, 1'b1, 32'h3, 32'h5, 32'h1},
      '{8'hA8, 32'h9, 32'h6, 3, 1'b0, 32'h9, 32'h6, 32'h1},
      '{8'h84, 32'h7FFF_FFFF, 32'h0, 3, 1'b1, 32'h8000_0000, 32'h9, 32'h1},
      '{8'h94, 32'h0, 32'h3, 5, 1'b1, 32'h0, 32'h9, 32'h1},
      '{8'hA4, 32'h3, 32'h0, 3, 1'b0, 32'h3, 32'hA, 32'h1}};
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      arm(rows[i].ctl, rows[i].load, rows[i].fin);
      step(rows[i].n, rows[i].up, 2 + 2 * (i % 2));
      expect_reg(OFS_COUNT, rows[i].count);
      expect_reg(OFS_STATUS, rows[i].status);
      check(event_count - event_base, rows[i].events);
    end
    // Lane 0 missing leaves the flag standing
    bus(1'b1, OFS_COMMAND, 32'h1, 4'h2);
    check({31'h0, underflow_flag}, 32'h1);
    bus(1'b1, OFS_COMMAND, 32'h1, 4'h1);
    @(posedge clock);
    check({31'h0, underflow_flag}, 32'h0);
    // Count is read only, unmapped reads zero
    bus(1'b1, OFS_COUNT, 32'h5, 4'hF);
    expect_reg(OFS_COUNT, 32'h3);
    expect_reg(8'h18, 32'h0);
    // Abort then interrupt gating, endless then single shot: close, pulse, reopen
    for (int g = 0; g < 4; g++) begin
      c = 8'h80 | {1'b0, g[0], 3'h0, g[1], 2'h0};
      arm(c, 32'h10, 32'h0);
      step(2, 1'b1, 2);
      bus(1'b1, OFS_CONTROL, {24'h0, c}, 4'hF);
      step(2, 1'b1, 2);
      expect_reg(OFS_COUNT, 32'h12);
      bus(1'b1, OFS_CONTROL, {24'h0, c | 8'h01}, 4'hF);
      step(1, 1'b1, 2);
      expect_reg(OFS_COUNT, g[0] ? 32'h13 : 32'h11);
    end
    // Automatic closure in a single shot holds until the gate is reopened
    arm(8'hC4, 32'h7FFF_FFFF, 32'h0);
    step(2, 1'b1, 2);
    check({31'h0, overflow_flag}, 32'h1);
    expect_reg(OFS_COUNT, 32'h8000_0000);
    bus(1'b1, OFS_CONTROL, 32'h0000_00C4, 4'hF);
    bus(1'b1, OFS_CONTROL, 32'h0000_00C5, 4'hF);
    step(1, 1'b1, 2);
    expect_reg(OFS_COUNT, 32'h8000_0001);
    // External gate rules the internal gate and restarts from load
    arm(8'h82, 32'h20, 32'h0);
    repeat (4) @(posedge clock);
    check({31'h0, gate_open}, 32'h0);
    external_gate_input <= 1'b1;
    repeat (5) @(posedge clock);
    check({31'h0, gate_open}, 32'h1);
    step(1, 1'b1, 2);
    external_gate_input <= 1'b0;
    step(1, 1'b1, 2);
    external_gate_input <= 1'b1;
    repeat (5) @(posedge clock);
    expect_reg(OFS_COUNT, 32'h20);
    // Second reset in mid-run: every register back to zero
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 6; a++) expect_reg(8'(a * 4), 32'h0);
    report_and_stop;
  end
endmodule
